// ===== core/reset_seq_pkg.sv
// Purpose: shared constants and types of the reset source sequencer
// Assumes: clock period of 40 ns; times are held in microseconds
// Notes:   counts derive from times; long counts are overridable at the top
package reset_seq_pkg;

   // clock and delay counter width
   localparam int CLK_PERIOD_NS = 40;
   localparam int DLY_W         = 25;
   typedef logic [DLY_W-1:0] dly_t;

   // start-up times as documented, in microseconds
   localparam int POR_TIME_US   = 72000;
   localparam int WAKE_18MS_US  = 18000;
   localparam int WAKE_250US_US = 250;
   localparam int WAKE_60MS_US  = 60000;
   localparam int WAKE_1S_US    = 1000000;
   localparam int WAKE_FAST_US  = 60;

   // least times, rounded up to whole clock cycles
   localparam int POR_CYC   = (POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int W18MS_CYC = (WAKE_18MS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int W250_CYC  = (WAKE_250US_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int W60MS_CYC = (WAKE_60MS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int W1S_CYC   = (WAKE_1S_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam dly_t WFAST_CYC = dly_t'((WAKE_FAST_US * 1000 + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS);

   // wake delay select and brown-out level encodings
   localparam logic [1:0] WSEL_250US  = 2'h2;
   localparam logic [1:0] WSEL_18MS   = 2'h3;
   localparam logic [1:0] WSEL_60MS   = 2'h0;
   localparam logic [1:0] WSEL_1S     = 2'h1;
   localparam logic [1:0] BO_DISABLED = 2'h3;

   // register byte offsets on the avalon slave
   localparam logic [3:0] REG_FUSE    = 4'h0;
   localparam logic [3:0] REG_STATUS  = 4'h4;
   localparam logic [3:0] REG_WAKE    = 4'h8;

   // fuse word layout, msb first
   typedef struct packed {
      logic       sleep_clock_disable;
      logic [1:0] wake_delay_select;
      logic [1:0] brownout_level_select;
   } fuse_s;

   // status word layout, msb first
   typedef struct packed {
      logic master_clear_n_level;
      logic brownout_hold;
      logic core_reset;
      logic timeout_flag;
      logic power_down_flag;
   } status_s;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [31:0] writedata;
   } avs_req_s;

   // reset values
   localparam logic [4:0] FUSE_RST  = 5'h1F;
   localparam logic [1:0] FLAGS_POR = 2'h3;
   localparam int         WAKE_W    = 8;

   typedef enum logic [2:0] {
      ST_POR_WAIT, ST_POR_COUNT, ST_RUN, ST_SLEEP, ST_WAKE_COUNT, ST_HOLD
   } seq_state_e;

endpackage

// ===== core/pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous to i_mclk
// Notes:   a change is taken only once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         i_mclk,
   input  wire logic         i_reset,
   input  wire logic         i_clk_en,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] q_reg;
   logic [W-1:0] agree;

   // stage one feeds only stage two
   assign agree = ~(s2_reg ^ s3_reg);
   assign o_q   = q_reg;

   // filtered output holds until stages two and three agree
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q_reg  <= '0;
      end else if (i_clk_en) begin
         s1_reg <= i_d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg  <= (agree & s3_reg) | (~agree & q_reg);
      end
   end
endmodule

// ===== core/start_delay_counter.sv
// Purpose: start-up delay counter, counts oscillator cycles down to one
// Assumes: load value is at least one
// Notes:   o_done is high in the last counted cycle; stop abandons a count
`timescale 1ns/1ps
module start_delay_counter
   import reset_seq_pkg::*;
(
   input  wire logic i_mclk,
   input  wire logic i_reset,
   input  wire logic i_clk_en,
   input  wire logic i_load,
   input  wire logic i_stop,
   input  wire dly_t i_load_val,
   output logic      o_done
);
   dly_t cnt_reg;
   logic run_reg;

   assign o_done = run_reg && (cnt_reg == dly_t'(1));

   // reload wins over stop so a fresh count is never lost
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
      end else if (i_clk_en) begin
         if (i_load) begin
            cnt_reg <= i_load_val;
            run_reg <= 1'b1;
         end else if (i_stop || o_done) begin
            run_reg <= 1'b0;
         end else if (run_reg) begin
            cnt_reg <= cnt_reg - dly_t'(1);
         end
      end
   end
endmodule

// ===== core/reset_source_sequencer.sv
// Purpose: reset source sequencer of a small microcontroller
// Assumes: i_mclk is the on-chip rc oscillator; i_reset marks power-up
// Notes:   registers on avalon-mm with one wait cycle per access
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module reset_source_sequencer #(
   parameter bit                  PROG_WAKE    = 1'b1,
   parameter reset_seq_pkg::dly_t POR_CYCLES   = reset_seq_pkg::dly_t'(reset_seq_pkg::POR_CYC),
   parameter reset_seq_pkg::dly_t W18MS_CYCLES = reset_seq_pkg::dly_t'(reset_seq_pkg::W18MS_CYC),
   parameter reset_seq_pkg::dly_t W250_CYCLES  = reset_seq_pkg::dly_t'(reset_seq_pkg::W250_CYC),
   parameter reset_seq_pkg::dly_t W60MS_CYCLES = reset_seq_pkg::dly_t'(reset_seq_pkg::W60MS_CYC),
   parameter reset_seq_pkg::dly_t W1S_CYCLES   = reset_seq_pkg::dly_t'(reset_seq_pkg::W1S_CYC)
) (
   input  wire logic                    i_mclk,
   input  wire logic                    i_reset,
   input  wire logic                    i_clk_en,
   input  wire logic                    i_master_clear_n,
   input  wire logic                    i_osc_running,
   input  wire logic [2:0]              i_supply_below,
   input  wire logic                    i_wdt_enable,
   input  wire logic                    i_wdt_overflow,
   input  wire logic                    i_sleep_req,
   input  wire logic                    i_wake_event,
   input  wire logic [7:0]              i_wake_flags,
   input  wire reset_seq_pkg::avs_req_s i_avs,
   output logic [31:0]                  o_readdata,
   output logic                         o_waitrequest,
   output logic                         o_core_reset,
   output logic                         o_timeout_flag,
   output logic                         o_power_down_flag,
   output logic                         o_sleep_clock_on
);
   import reset_seq_pkg::*;

   seq_state_e   state_reg;
   seq_state_e   state_next;
   fuse_s        fuse_reg;
   logic [1:0]   flags_reg;
   logic [1:0]   flags_next;
   logic [7:0]   pend_reg;
   logic [7:0]   pend_next;
   logic [7:0]   pend_clr;
   logic         core_reset_reg;
   logic         sleep_clk_reg;
   logic         wait_reg;
   logic [31:0]  rdata_reg;
   logic [4:0]   pins_s;
   logic         master_clear_n_ok;
   logic         osc_ok;
   logic [2:0]   supply_s;
   logic         bo_hit;
   logic         bo_hold;
   logic         wdt_evt;
   logic         hold_any;
   logic         dly_load;
   logic         dly_stop;
   logic         dly_done;
   dly_t         dly_val;
   dly_t         wake_cycles;
   dly_t         prog_cycles;
   logic         av_req;
   logic         av_acc;
   logic         wr_fuse;
   logic         wr_wake;
   logic [31:0]  rd_mux;
   status_s      status_w;

   // pins from the board and supply monitor pass the three-stage filter
   pin_sync #(
      .W (5)
   ) u_pin_sync (
      .i_mclk   (i_mclk),
      .i_reset  (i_reset),
      .i_clk_en (i_clk_en),
      .i_d      ({i_master_clear_n, i_osc_running, i_supply_below}),
      .o_q      (pins_s)
   );

   assign master_clear_n_ok  = pins_s[4];
   assign osc_ok   = pins_s[3];
   assign supply_s = pins_s[2:0];

   // brown-out comparator picked by the fuse level field
   assign bo_hit  = (fuse_reg.brownout_level_select == BO_DISABLED) ? 1'b0 :
                    supply_s[fuse_reg.brownout_level_select];
   assign bo_hold = bo_hit && (fuse_reg.brownout_level_select != BO_DISABLED);

   // watchdog only counts while it is enabled
   assign wdt_evt  = i_wdt_enable && i_wdt_overflow;
   // any single source forces reset
   assign hold_any = wdt_evt || !master_clear_n_ok || bo_hold;

   // wakeup start-up delay; fast case needs the oscillator kept running
   always_comb begin
      case (fuse_reg.wake_delay_select)
         WSEL_250US: prog_cycles = fuse_reg.sleep_clock_disable ? W250_CYCLES
                                                                : WFAST_CYC;
         WSEL_18MS:  prog_cycles = W18MS_CYCLES;
         WSEL_60MS:  prog_cycles = W60MS_CYCLES;
         WSEL_1S:    prog_cycles = W1S_CYCLES;
         default:    prog_cycles = W18MS_CYCLES;
      endcase
   end

   assign wake_cycles = PROG_WAKE ? prog_cycles : W18MS_CYCLES;

   // sequencer; hold reasons take priority over sleep and wakeup
   always_comb begin
      state_next = state_reg;
      dly_load   = 1'b0;
      dly_val    = POR_CYCLES;
      case (state_reg)
         ST_POR_WAIT: begin
            // a board that lets master clear rise early defeats this gate
            if (osc_ok && master_clear_n_ok) begin
               state_next = ST_POR_COUNT;
               dly_load   = 1'b1;
            end
         end
         ST_POR_COUNT: begin
            if (!osc_ok || !master_clear_n_ok) begin
               state_next = ST_POR_WAIT;
            end else if (dly_done) begin
               state_next = hold_any ? ST_HOLD : ST_RUN;
            end
         end
         ST_RUN: begin
            if (hold_any) begin
               state_next = ST_HOLD;
            end else if (i_sleep_req) begin
               state_next = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (hold_any) begin
               state_next = ST_HOLD;
            end else if (i_wake_event) begin
               state_next = ST_WAKE_COUNT;
               dly_load   = 1'b1;
               dly_val    = wake_cycles;
            end
         end
         ST_WAKE_COUNT: begin
            if (hold_any) begin
               state_next = ST_HOLD;
            end else if (dly_done) begin
               state_next = ST_RUN;
            end
         end
         ST_HOLD: begin
            // release goes straight to run: no start-up delay here
            if (!hold_any) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_POR_WAIT;
         end
      endcase
   end

   assign dly_stop = (state_next != ST_POR_COUNT) && (state_next != ST_WAKE_COUNT);

   // start-up delay counter runs on the oscillator clock itself
   start_delay_counter u_start_delay_counter (
      .i_mclk     (i_mclk),
      .i_reset    (i_reset),
      .i_clk_en   (i_clk_en),
      .i_load     (dly_load),
      .i_stop     (dly_stop),
      .i_load_val (dly_val),
      .o_done     (dly_done)
   );

   // timeout and power-down flags change only on entry to a reset
   always_comb begin
      flags_next = flags_reg;
      if (wdt_evt && state_reg == ST_SLEEP) begin
         flags_next = 2'h0;
      end else if (wdt_evt && state_reg == ST_RUN) begin
         flags_next = 2'h1;
      end else if (!master_clear_n_ok && state_reg == ST_SLEEP) begin
         flags_next = 2'h2;
      end
   end

   // sequencer state, reset output and sleep clock gate
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         state_reg      <= ST_POR_WAIT;
         core_reset_reg <= 1'b1;
         flags_reg      <= FLAGS_POR;
         sleep_clk_reg  <= 1'b1;
      end else if (i_clk_en) begin
         state_reg      <= state_next;
         core_reset_reg <= (state_next != ST_RUN);
         flags_reg      <= flags_next;
         sleep_clk_reg  <= !(state_next == ST_SLEEP && fuse_reg.sleep_clock_disable);
      end
   end

   // avalon slave: one wait cycle, then the access takes effect
   assign av_req  = i_avs.read || i_avs.write;
   assign av_acc  = av_req && !wait_reg;
   assign wr_fuse = av_acc && i_avs.write && (i_avs.address == REG_FUSE);
   assign wr_wake = av_acc && i_avs.write && (i_avs.address == REG_WAKE);
   assign pend_clr = wr_wake ? i_avs.writedata[WAKE_W-1:0] : 8'h00;

   // new wake flags win over a software clear in the same cycle
   assign pend_next = (pend_reg & ~pend_clr) | i_wake_flags;

   assign status_w = '{master_clear_n_level:      master_clear_n_ok,
                       brownout_hold:   bo_hold,
                       core_reset:      core_reset_reg,
                       timeout_flag:    flags_reg[1],
                       power_down_flag: flags_reg[0]};

   // read decode; unmapped offsets read as zero
   assign rd_mux = (i_avs.address == REG_FUSE)   ? {27'h0000000, fuse_reg} :
                   (i_avs.address == REG_STATUS) ? {27'h0000000, status_w} :
                   (i_avs.address == REG_WAKE)   ? {24'h000000, pend_reg}  :
                                                   32'h00000000;

   // register file and bus handshake
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         fuse_reg  <= fuse_s'(FUSE_RST);
         pend_reg  <= 8'h00;
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h00000000;
      end else if (i_clk_en) begin
         wait_reg <= !(av_req && wait_reg);
         if (av_req && wait_reg) begin
            rdata_reg <= rd_mux;
         end
         if (wr_fuse) begin
            fuse_reg <= fuse_s'(i_avs.writedata[4:0]);
         end
         // power-up, or a write of ones to the wake register, clears the pending flags
         pend_reg <= pend_next;
      end
   end

   assign o_readdata        = rdata_reg;
   assign o_waitrequest     = wait_reg;
   assign o_core_reset      = core_reset_reg;
   assign o_timeout_flag    = flags_reg[1];
   assign o_power_down_flag = flags_reg[0];
   assign o_sleep_clock_on  = sleep_clk_reg;

   // checks
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_reset);

   property p_por_hold;
      state_reg inside {ST_POR_WAIT, ST_POR_COUNT} |-> o_core_reset;
   endproperty
   a_por_hold: assert property (p_por_hold)
      else $error("core left reset during power-on");

   property p_count_gate;
      (i_clk_en && state_reg == ST_POR_WAIT && !(osc_ok && master_clear_n_ok))
         |=> state_reg == ST_POR_WAIT;
   endproperty
   a_count_gate: assert property (p_count_gate)
      else $error("delay count started without oscillator and clear");

   property p_por_release;
      (i_clk_en && state_reg == ST_POR_COUNT && dly_done && osc_ok && !hold_any)
         |=> (state_reg == ST_RUN) && !o_core_reset;
   endproperty
   a_por_release: assert property (p_por_release)
      else $error("power-on count end did not release reset");

   property p_hold_no_delay;
      (i_clk_en && state_reg == ST_HOLD && !hold_any) |=> state_reg == ST_RUN ##1 1'b1;
   endproperty
   a_hold_no_delay: assert property (p_hold_no_delay)
      else $error("non power-on reset used the start-up delay");

   property p_wake_reset;
      (i_clk_en && state_reg == ST_SLEEP && i_wake_event && !hold_any)
         |=> o_core_reset && state_reg == ST_WAKE_COUNT;
   endproperty
   a_wake_reset: assert property (p_wake_reset)
      else $error("wakeup did not reset the device");

   property p_wake_fixed;
      !PROG_WAKE |-> wake_cycles == W18MS_CYCLES;
   endproperty
   a_wake_fixed: assert property (p_wake_fixed)
      else $error("fixed wake delay wrong");

   property p_wake_1s;
      (PROG_WAKE && fuse_reg.wake_delay_select == WSEL_1S) |-> wake_cycles == W1S_CYCLES;
   endproperty
   a_wake_1s: assert property (p_wake_1s)
      else $error("wake select 01 gave wrong delay");

   property p_wake_fast;
      (PROG_WAKE && fuse_reg.wake_delay_select == WSEL_250US
         && !fuse_reg.sleep_clock_disable) |-> wake_cycles == WFAST_CYC;
   endproperty
   a_wake_fast: assert property (p_wake_fast)
      else $error("fast wake delay wrong");

   property p_pend_set;
      (i_clk_en && i_wake_flags != 8'h00)
         |=> (pend_reg & $past(i_wake_flags)) == $past(i_wake_flags);
   endproperty
   a_pend_set: assert property (p_pend_set)
      else $error("wake pending flag lost");

   property p_bo_hold;
      (i_clk_en && bo_hold) |=> o_core_reset && state_reg != ST_RUN;
   endproperty
   a_bo_hold: assert property (p_bo_hold)
      else $error("brown-out did not hold reset");

   property p_bo_level;
      (fuse_reg.brownout_level_select == 2'h0 && supply_s[0]) |-> bo_hold;
   endproperty
   a_bo_level: assert property (p_bo_level)
      else $error("brown-out level select ignored");

   property p_bo_off;
      fuse_reg.brownout_level_select == BO_DISABLED |-> !bo_hold;
   endproperty
   a_bo_off: assert property (p_bo_off)
      else $error("disabled brown-out still holds");

   property p_wdt;
      (i_clk_en && wdt_evt && state_reg == ST_RUN) |=> o_core_reset && o_timeout_flag == 1'b0;
   endproperty
   a_wdt: assert property (p_wdt)
      else $error("watchdog overflow did not reset");

   property p_master_clear_n;
      (i_clk_en && !master_clear_n_ok) |=> o_core_reset;
   endproperty
   a_master_clear_n: assert property (p_master_clear_n)
      else $error("master clear low without reset");

   property p_flags_wdt_sleep;
      (i_clk_en && wdt_evt && state_reg == ST_SLEEP)
         |=> {o_timeout_flag, o_power_down_flag} == 2'h0;
   endproperty
   a_flags_wdt_sleep: assert property (p_flags_wdt_sleep)
      else $error("watchdog in power-down flags wrong");

   property p_flags_master_clear_n_run;
      (i_clk_en && !master_clear_n_ok && !wdt_evt && state_reg == ST_RUN)
         |=> $stable({o_timeout_flag, o_power_down_flag});
   endproperty
   a_flags_master_clear_n_run: assert property (p_flags_master_clear_n_run)
      else $error("external reset while active changed flags");

   c_por_done: cover property (state_reg == ST_POR_COUNT ##1 state_reg == ST_RUN);
   c_wake:     cover property (state_reg == ST_WAKE_COUNT ##1 state_reg == ST_RUN);
   c_brownout: cover property (bo_hold ##1 state_reg == ST_HOLD);
   c_wdt:      cover property (wdt_evt && state_reg == ST_SLEEP);
endmodule

// ===== sim/board_model.sv
// Purpose: board side of the sequencer: clear pin network and supply monitor
// Assumes: the bench commands ramp, button press and supply sag depth
// Notes:   clear stays low for the whole ramp, as a delay network would hold it
`timescale 1ns/1ps
module board_model (
   input  wire logic       i_ramp,
   input  wire logic       i_press,
   input  wire logic [1:0] i_sag,
   output logic            o_master_clear_n,
   output logic            o_osc_running,
   output logic [2:0]      o_supply_below
);
   // clear held low while the supply rises or the button is down
   assign o_master_clear_n = !(i_ramp || i_press);
   assign o_osc_running    = !i_ramp;
   // a sag of n puts the supply under the lowest n thresholds
   assign o_supply_below   = {i_sag > 2'h2, i_sag > 2'h1, i_sag > 2'h0};
endmodule

// ===== sim/tb.sv
// Purpose: self-checking bench of the reset source sequencer
// Assumes: short delay counts set below; clock and watchdog enables driven here
// Notes:   pin filter latency is unknown to a few edges, so lengths get slack
`timescale 1ns/1ps
module tb;
   import reset_seq_pkg::*;
   localparam int WX[5] = '{20, 30, 25, 35, int'(WFAST_CYC)};
   logic [4:0] fz[5] = '{5'h1B, 5'h1F, 5'h13, 5'h17, 5'h0B};
   logic i_mclk = 1'b0, i_reset, ramp, press, wdt_ovf, sleep_req, wake_ev, clk_en, wdt_en;
   logic [1:0] sag;
   logic [7:0] wflags;
   avs_req_s avs;
   logic [31:0] rdata, q;
   logic waitreq, core_rst, to_f, pd_f, sclk_on, master_clear_n_n, osc;
   logic [2:0] below;
   int error_cnt = 0, tests_run = 0, n;

   // 25 MHz clock
   always #20 i_mclk = ~i_mclk;

   board_model pm (.i_ramp(ramp), .i_press(press), .i_sag(sag), .o_master_clear_n(master_clear_n_n),
      .o_osc_running(osc), .o_supply_below(below));
   reset_source_sequencer #(.POR_CYCLES(25'h28), .W18MS_CYCLES(25'h1E),
      .W250_CYCLES(25'h14), .W60MS_CYCLES(25'h19), .W1S_CYCLES(25'h23)) dut (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_clk_en(clk_en), .i_master_clear_n(master_clear_n_n),
      .i_osc_running(osc), .i_supply_below(below), .i_wdt_enable(wdt_en),
      .i_wdt_overflow(wdt_ovf), .i_sleep_req(sleep_req), .i_wake_event(wake_ev),
      .i_wake_flags(wflags), .i_avs(avs), .o_readdata(rdata), .o_waitrequest(waitreq),
      .o_core_reset(core_rst), .o_timeout_flag(to_f), .o_power_down_flag(pd_f),
      .o_sleep_clock_on(sclk_on));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge i_mclk);
   endtask

   // one avalon access; request held until waitrequest is sampled low, however long
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      avs <= '{read: !w, write: w, address: a, writedata: d};
      @(posedge i_mclk);
      while (waitreq !== 1'b0) begin
         @(posedge i_mclk);
      end
      q = rdata;
      avs <= '0;
   endtask

   // 0 sleep, 1 wake, 2 watchdog overflow, one cycle each
   task automatic pulse(input int s);
      @(posedge i_mclk);
      sleep_req <= (s == 0);
      wake_ev   <= (s == 1);
      wdt_ovf   <= (s == 2);
      @(posedge i_mclk);
      {sleep_req, wake_ev, wdt_ovf} <= 3'h0;
   endtask

   // waits a few cycles for reset to rise, then counts how long it stays
   task automatic rst_len();
      int k;
      k = 0;
      n = 0;
      @(negedge i_mclk);
      while (core_rst !== 1'b1 && k < 8) begin
         k++;
         @(negedge i_mclk);
      end
      while (core_rst === 1'b1 && n < 3000) begin
         n++;
         @(negedge i_mclk);
      end
   endtask

   task automatic t_por();
      bus(1'b0, REG_STATUS, 32'h0);
      chk("por status", 32'h07, q);
      tick(5);
      ramp <= 1'b0;
      rst_len();
      chk("por length", 32'h1, (n >= 40 && n <= 48));
   endtask

   task automatic t_wdt(input logic sl, input logic [1:0] ef);
      if (sl) pulse(0);
      pulse(2);
      rst_len();
      chk("wdt length", 32'h1, n);
      chk("wdt flags", ef, {to_f, pd_f});
   endtask

   // overflow dropped first with the watchdog disabled, then with the clock enable low
   task automatic t_gate();
      for (int g = 0; g < 2; g++) begin
         @(posedge i_mclk);
         wdt_en <= (g == 1);
         clk_en <= (g == 0);
         pulse(2);
         rst_len();
         chk("wdt gated", 32'h0, n);
         chk("gated flags", 2'h1, {to_f, pd_f});
      end
      @(posedge i_mclk);
      {wdt_en, clk_en} <= 2'h3;
   endtask

   task automatic t_master_clear_n(input logic sl, input logic [1:0] ef);
      if (sl) pulse(0);
      @(posedge i_mclk);
      press <= 1'b1;
      tick(20);
      chk("master_clear_n hold", 1'b1, core_rst);
      chk("master_clear_n flags", ef, {to_f, pd_f});
      press <= 1'b0;
      tick(8);
      chk("master_clear_n release", 1'b0, core_rst);
   endtask

   // each wake delay code, pending flags kept across the wake reset
   task automatic t_wake(input logic [4:0] f, input int w);
      bus(1'b1, REG_FUSE, {27'h0, f});
      @(posedge i_mclk);
      wflags <= 8'hA5;
      @(posedge i_mclk);
      wflags <= 8'h00;
      pulse(0);
      tick(3);
      chk("sleep clock", !f[4], sclk_on);
      pulse(1);
      rst_len();
      chk("wake length", 32'h1, (n >= w - 1 && n <= w + 2));
      bus(1'b0, REG_WAKE, 32'h0);
      chk("wake pending", 32'hA5, q);
      bus(1'b1, REG_WAKE, 32'hFF);
   endtask

   // level 00 trips on a shallow sag, 01 does not, 11 never
   task automatic t_bo();
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, REG_FUSE, {27'h0, 3'h7, i[1:0] + (i == 2)});
         @(posedge i_mclk);
         sag <= 2'h1;
         tick(10);
         chk("brownout hold", i == 0, core_rst);
         sag <= 2'h0;
         tick(10);
         chk("brownout end", 1'b0, core_rst);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // hang guard at 25000 cycles, well beyond the expected run of about 2000 cycles
   initial begin
      #1000000;
      error_cnt++;
      tally_and_finish();
   end

   // main sequence
   initial begin
      {i_reset, ramp, press, wdt_ovf, sleep_req, wake_ev} = 6'h30;
      {clk_en, wdt_en} = 2'h3;
      sag = 2'h0;
      wflags = 8'h00;
      avs = '0;
      tick(3);
      i_reset <= 1'b0;
      t_por();
      t_wdt(1'b0, 2'h1);
      t_gate();
      t_master_clear_n(1'b0, 2'h1);
      t_wdt(1'b1, 2'h0);
      t_master_clear_n(1'b1, 2'h2);
      for (int i = 0; i < 5; i++) t_wake(fz[i], WX[i]);
      t_bo();
      tally_and_finish();
   end
endmodule
